/* File: core/shift_and_pkg.sv */
// Package of opcodes, flag positions, bus constants and reset values
package shift_and_pkg;
    localparam logic [15:0] IDLE_ADDR     = 16'hFFFF;
    localparam logic [15:0] RESET_PC      = 16'h0000;
    localparam logic [7:0]  PREFIX_Y      = 8'h18;
    localparam logic [7:0]  OP_AND_A_IMM  = 8'h84;
    localparam logic [7:0]  OP_AND_A_DIR  = 8'h94;
    localparam logic [7:0]  OP_AND_A_EXT  = 8'hB4;
    localparam logic [7:0]  OP_AND_A_IDX  = 8'hA4;
    localparam logic [7:0]  OP_AND_B_IMM  = 8'hC4;
    localparam logic [7:0]  OP_AND_B_DIR  = 8'hD4;
    localparam logic [7:0]  OP_AND_B_EXT  = 8'hF4;
    localparam logic [7:0]  OP_AND_B_IDX  = 8'hE4;
    localparam logic [7:0]  OP_ASL_A      = 8'h48;
    localparam logic [7:0]  OP_ASL_B      = 8'h58;
    localparam logic [7:0]  OP_ASL_EXT    = 8'h78;
    localparam logic [7:0]  OP_ASL_IDX    = 8'h68;
    localparam logic [7:0]  OP_ASL_D      = 8'h05;
    localparam logic [7:0]  OP_ASR_A      = 8'h47;
    localparam logic [7:0]  OP_ASR_B      = 8'h57;
    localparam logic [7:0]  OP_ASR_EXT    = 8'h77;
    localparam logic [7:0]  OP_ASR_IDX    = 8'h67;
    // Flag positions: S X H I N Z V C
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam logic [7:0]  FLAGS_RESET   = 8'hD0;
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [15:0] INDEX_RESET   = 16'h0000;
    typedef enum logic [1:0] {ALU_AND, ALU_ASL, ALU_ASR} alu_op_e;
endpackage

/* File: core/shift_and_alu.sv */
// Combinational result and flag logic for AND and 8-bit shifts
`timescale 1ns/1ps
module shift_and_alu (
    input  wire logic [1:0] op,
    input  wire logic [7:0] acc_in,
    input  wire logic [7:0] mem_in,
    input  wire logic [7:0] flags_in,
    output logic      [7:0] result,
    output logic      [7:0] flags_out
);
    logic n_f;
    logic c_f;
    always_comb begin
        flags_out = flags_in;
        c_f = flags_in[shift_and_pkg::FLAG_C];
        case (shift_and_pkg::alu_op_e'(op))
            shift_and_pkg::ALU_AND: begin
                result = acc_in & mem_in;
            end
            shift_and_pkg::ALU_ASL: begin
                result = {mem_in[6:0], 1'b0};
                c_f    = mem_in[7];
            end
            shift_and_pkg::ALU_ASR: begin
                result = {mem_in[7], mem_in[7:1]};
                c_f    = mem_in[0];
            end
            default: begin
                result = mem_in;
            end
        endcase
        n_f = result[7];
        flags_out[shift_and_pkg::FLAG_N] = n_f;
        flags_out[shift_and_pkg::FLAG_Z] = (result == 8'h00);
        flags_out[shift_and_pkg::FLAG_C] = c_f;
        if (shift_and_pkg::alu_op_e'(op) == shift_and_pkg::ALU_AND) begin
            flags_out[shift_and_pkg::FLAG_V] = 1'b0;
        end else begin
            flags_out[shift_and_pkg::FLAG_V] = n_f ^ c_f;
        end
    end
endmodule

/* File: core/and_shift_left_right_exec.sv */
// Execution core for AND, arithmetic shift left/right and double shift
// What this block does
// - AND sets N, Z; clears V
// - AND opcodes for A, B and Y prefix
// - AND cycle counts, indexed idle read, reads only
// - Left shift, zero into bit 0, N Z
// - Left shift carry from old bit 7
// - Shifts set V as N xor C
// - Left shift opcodes and cycle counts
// - Memory shift: read, idle, write back
// - Double shift left, opcode 05, three cycles
// - Right shift keeps bit 7, carry old bit 0
// - Right shift opcodes, same timing as left
// - Double accumulator is A high, B low
`timescale 1ns/1ps
module and_shift_left_right_exec (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  bus_rdata,
    input  wire logic [15:0] index_x,
    input  wire logic [15:0] index_y,
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_wdata,
    output logic             bus_read_write,
    output logic      [7:0]  acc_a,
    output logic      [7:0]  acc_b,
    output logic      [7:0]  condition_flags,
    output logic             illegal_op
);
    typedef enum {S_FETCH, S_OPC2, S_OPND, S_LOW, S_IDLE, S_DATA, S_IDLE2, S_WRITE} state_e;

    // =====================================================
    // State
    // =====================================================
    state_e      state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0]  op_q, op_d;
    logic        pre_y_q, pre_y_d;
    logic [7:0]  hi_q, hi_d;
    logic [15:0] ea_q, ea_d;
    logic [7:0]  mem_q, mem_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        rw_q, rw_d;
    logic [7:0]  a_q, a_d;
    logic [7:0]  b_q, b_d;
    logic [7:0]  ccr_q, ccr_d;
    logic        ill_q, ill_d;

    // =====================================================
    // Decode of the latched opcode
    // =====================================================
    logic [3:0]  lo;
    logic [3:0]  hi;
    logic        is_and;
    logic        and_b;
    logic        is_shift;
    logic        is_right;
    logic        acc_form;
    logic        sel_b;
    logic [1:0]  alu_op;
    logic [7:0]  alu_acc;
    logic [7:0]  alu_mem;
    logic [7:0]  alu_res;
    logic [7:0]  alu_flags;
    logic [15:0] dbl_res;

    always_comb begin
        lo       = op_q[3:0];
        hi       = op_q[7:4];
        is_and   = (lo == 4'h4) && op_q[7];
        and_b    = op_q[6];
        is_shift = (lo == 4'h8 || lo == 4'h7) && (hi >= 4'h4) && (hi <= 4'h7);
        is_right = (lo == 4'h7);
        acc_form = (hi == 4'h4) || (hi == 4'h5);
        sel_b    = is_and ? and_b : (hi == 4'h5);
        if (is_and) begin
            alu_op = 2'(shift_and_pkg::ALU_AND);
        end else if (is_right) begin
            alu_op = 2'(shift_and_pkg::ALU_ASR);
        end else begin
            alu_op = 2'(shift_and_pkg::ALU_ASL);
        end
        alu_acc = sel_b ? b_q : a_q;
        // AND always combines with the byte on the bus in its last cycle
        if (is_and) begin
            alu_mem = bus_rdata;
        end else if (is_shift && acc_form) begin
            alu_mem = alu_acc;
        end else begin
            alu_mem = mem_q;
        end
        dbl_res = {a_q[6:0], b_q, 1'b0};
    end

    shift_and_alu u_alu (
        .op        (alu_op),
        .acc_in    (alu_acc),
        .mem_in    (alu_mem),
        .flags_in  (ccr_q),
        .result    (alu_res),
        .flags_out (alu_flags)
    );

    // =====================================================
    // Sequencer and bus cycle generation
    // =====================================================
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        op_d    = op_q;
        pre_y_d = pre_y_q;
        hi_d    = hi_q;
        ea_d    = ea_q;
        mem_d   = mem_q;
        wdata_d = wdata_q;
        a_d     = a_q;
        b_d     = b_q;
        ccr_d   = ccr_q;
        ill_d   = ill_q;
        rw_d    = 1'b1;
        addr_d  = addr_q;
        case (state_q)
            S_FETCH: begin
                op_d    = bus_rdata;
                pre_y_d = (bus_rdata == shift_and_pkg::PREFIX_Y);
                pc_d    = pc_q + 16'h0001;
                addr_d  = pc_q + 16'h0001;
                state_d = (bus_rdata == shift_and_pkg::PREFIX_Y) ? S_OPC2 : S_OPND;
            end
            S_OPC2: begin
                op_d    = bus_rdata;
                pc_d    = pc_q + 16'h0001;
                addr_d  = pc_q + 16'h0001;
                state_d = S_OPND;
            end
            S_OPND: begin
                // Cycle after opcode: immediate, direct, high, offset or discarded
                ill_d   = 1'b0;
                if (op_q == shift_and_pkg::OP_ASL_D) begin
                    {a_d, b_d}        = dbl_res;
                    ccr_d             = ccr_q;
                    ccr_d[shift_and_pkg::FLAG_C] = a_q[7];
                    ccr_d[shift_and_pkg::FLAG_N] = dbl_res[15];
                    ccr_d[shift_and_pkg::FLAG_Z] = (dbl_res == 16'h0000);
                    ccr_d[shift_and_pkg::FLAG_V] = dbl_res[15] ^ a_q[7];
                    addr_d  = shift_and_pkg::IDLE_ADDR;
                    state_d = S_IDLE2;
                end else if (is_shift && acc_form) begin
                    if (sel_b) begin
                        b_d = alu_res;
                    end else begin
                        a_d = alu_res;
                    end
                    ccr_d   = alu_flags;
                    addr_d  = pc_q;
                    state_d = S_FETCH;
                end else if (is_and && hi[1:0] == 2'b00) begin
                    // Immediate byte is on the bus now, so no third cycle
                    if (and_b) begin
                        b_d = alu_res;
                    end else begin
                        a_d = alu_res;
                    end
                    ccr_d   = alu_flags;
                    pc_d    = pc_q + 16'h0001;
                    addr_d  = pc_q + 16'h0001;
                    state_d = S_FETCH;
                end else if (is_and && hi[1:0] == 2'b01) begin
                    pc_d    = pc_q + 16'h0001;
                    ea_d    = {8'h00, bus_rdata};
                    addr_d  = {8'h00, bus_rdata};
                    state_d = S_DATA;
                    mem_d   = mem_q;
                end else if ((is_and && hi[1:0] == 2'b11) || (is_shift && hi == 4'h7)) begin
                    hi_d    = bus_rdata;
                    pc_d    = pc_q + 16'h0001;
                    addr_d  = pc_q + 16'h0001;
                    state_d = S_LOW;
                end else if ((is_and && hi[1:0] == 2'b10) || (is_shift && hi == 4'h6)) begin
                    pc_d    = pc_q + 16'h0001;
                    ea_d    = (pre_y_q ? index_y : index_x) + {8'h00, bus_rdata};
                    addr_d  = shift_and_pkg::IDLE_ADDR;
                    state_d = S_IDLE;
                end else begin
                    ill_d   = 1'b1;
                    addr_d  = pc_q;
                    state_d = S_FETCH;
                end
            end
            S_LOW: begin
                pc_d    = pc_q + 16'h0001;
                ea_d    = {hi_q, bus_rdata};
                addr_d  = {hi_q, bus_rdata};
                state_d = S_DATA;
            end
            S_IDLE: begin
                addr_d  = ea_q;
                state_d = S_DATA;
            end
            S_DATA: begin
                // Operand read of an AND is its last cycle
                if (is_and) begin
                    if (and_b) begin
                        b_d = alu_res;
                    end else begin
                        a_d = alu_res;
                    end
                    ccr_d   = alu_flags;
                    addr_d  = pc_q;
                    state_d = S_FETCH;
                end else begin
                    mem_d   = bus_rdata;
                    addr_d  = shift_and_pkg::IDLE_ADDR;
                    state_d = S_WRITE;
                end
            end
            S_WRITE: begin
                wdata_d = alu_res;
                ccr_d   = alu_flags;
                addr_d  = ea_q;
                rw_d    = 1'b0;
                state_d = S_IDLE2;
            end
            S_IDLE2: begin
                addr_d  = pc_q;
                state_d = S_FETCH;
            end
            default: begin
                addr_d  = pc_q;
                state_d = S_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_FETCH;
            pc_q    <= shift_and_pkg::RESET_PC;
            op_q    <= 8'h00;
            pre_y_q <= 1'b0;
            hi_q    <= 8'h00;
            ea_q    <= shift_and_pkg::INDEX_RESET;
            mem_q   <= 8'h00;
            addr_q  <= shift_and_pkg::RESET_PC;
            wdata_q <= 8'h00;
            rw_q    <= 1'b1;
            a_q     <= shift_and_pkg::ACC_RESET;
            b_q     <= shift_and_pkg::ACC_RESET;
            ccr_q   <= shift_and_pkg::FLAGS_RESET;
            ill_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            op_q    <= op_d;
            pre_y_q <= pre_y_d;
            hi_q    <= hi_d;
            ea_q    <= ea_d;
            mem_q   <= mem_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rw_q    <= rw_d;
            a_q     <= a_d;
            b_q     <= b_d;
            ccr_q   <= ccr_d;
            ill_q   <= ill_d;
        end
    end

    assign bus_addr        = addr_q;
    assign bus_wdata       = wdata_q;
    assign bus_read_write  = rw_q;
    assign acc_a           = a_q;
    assign acc_b           = b_q;
    assign condition_flags = ccr_q;
    assign illegal_op      = ill_q;
endmodule

/* File: testbench/and_shift_left_right_exec_asserts.sv */
// Checker of bus sequencing and flag results for the AND and shift group
`timescale 1ns/1ps
module and_shift_left_right_exec_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  bus_rdata,
    input wire logic [15:0] index_x,
    input wire logic [15:0] index_y,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic        bus_read_write,
    input wire logic [7:0]  acc_a,
    input wire logic [7:0]  acc_b,
    input wire logic [7:0]  condition_flags,
    input wire logic        illegal_op
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Operand history
    logic [7:0] rd1_q;
    logic [7:0] rd2_q;
    // Two deep so the write cycle still sees the operand read before the idle
    always_ff @(posedge clk) begin
        rd1_q <= bus_rdata;
        rd2_q <= rd1_q;
    end
    // ==========================================
    // Properties
    property p_wr_idle; !bus_read_write |-> $past(bus_addr) == 16'hFFFF; endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write not preceded by idle");
    property p_wr_same; !bus_read_write |-> $past(bus_addr, 2) == bus_addr; endproperty
    a_wr_same: assert property (p_wr_same) else $error("write address differs from read");
    property p_wr_one; !bus_read_write |=> bus_read_write; endproperty
    a_wr_one: assert property (p_wr_one) else $error("two write cycles in a row");
    property p_wr_data;
        !bus_read_write |-> bus_wdata == {rd2_q[6:0], 1'b0} || bus_wdata == {rd2_q[7], rd2_q[7:1]};
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data is no shift of operand");
    property p_wr_nz;
        !bus_read_write |=> condition_flags[3] == $past(bus_wdata[7]) && condition_flags[2] == ($past(bus_wdata) == 8'h00);
    endproperty
    a_wr_nz: assert property (p_wr_nz) else $error("N or Z wrong after memory shift");
    property p_wr_v; !bus_read_write |=> condition_flags[1] == (condition_flags[3] ^ condition_flags[0]); endproperty
    a_wr_v: assert property (p_wr_v) else $error("V not N xor C after shift");
    property p_c_left;
        !bus_read_write && bus_wdata != {rd2_q[7], rd2_q[7:1]} |=> condition_flags[0] == $past(rd2_q[7]);
    endproperty
    a_c_left: assert property (p_c_left) else $error("carry wrong after left shift");
    property p_c_right;
        !bus_read_write && bus_wdata != {rd2_q[6:0], 1'b0} |=> condition_flags[0] == $past(rd2_q[0]);
    endproperty
    a_c_right: assert property (p_c_right) else $error("carry wrong after right shift");
    property p_upper; condition_flags[7:4] == shift_and_pkg::FLAGS_RESET[7:4]; endproperty
    a_upper: assert property (p_upper) else $error("S X H I flags changed");
    property p_dbl;
        (bus_read_write && bus_rdata == 8'h05) ##1 (bus_addr == $past(bus_addr) + 16'h0001) |=> bus_addr == 16'hFFFF;
    endproperty
    a_dbl: assert property (p_dbl) else $error("double shift lacks idle cycle");
    c_write: cover property (!bus_read_write);
    c_idle: cover property (bus_addr == 16'hFFFF ##1 bus_addr != 16'hFFFF);
    c_zero: cover property (condition_flags[2] && condition_flags[0]);
endmodule

bind and_shift_left_right_exec and_shift_left_right_exec_chk chk_u (
    .clk(clk), .rst(rst), .bus_rdata(bus_rdata), .index_x(index_x), .index_y(index_y),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_read_write(bus_read_write),
    .acc_a(acc_a), .acc_b(acc_b), .condition_flags(condition_flags), .illegal_op(illegal_op)
);

/* File: testbench/bus_mem.sv */
// Program and data memory model on the processor bus
`timescale 1ns/1ps
module bus_mem (
    input  wire logic        clk,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_read_write,
    output logic      [7:0]  bus_rdata
);
    logic [7:0] mem [65536];
    // Unwritten space holds an opcode outside the group
    initial begin
        foreach (mem[i]) mem[i] = 8'h01;
    end
    // Not driving during a write, so show the inverse rather than a stale match
    assign bus_rdata = bus_read_write ? mem[bus_addr] : ~mem[bus_addr];
    always @(posedge clk) begin
        if (!bus_read_write) begin
            mem[bus_addr] <= bus_wdata;
        end
    end
endmodule

/* File: testbench/test_and_shift_left_right_exec.sv */
// Self-checking bench for the AND and arithmetic shift instructions
`timescale 1ns/1ps
module test_and_shift_left_right_exec;
    logic        clk;
    logic        rst;
    logic [15:0] index_x;
    logic [15:0] index_y;
    logic [7:0]  bus_rdata;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_read_write;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [7:0]  condition_flags;
    logic        illegal_op;
    logic [15:0] pc;
    int          num_errors;
    int          compares;
    and_shift_left_right_exec dut_u (.clk(clk), .rst(rst), .bus_rdata(bus_rdata), .index_x(index_x),
        .index_y(index_y), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_read_write(bus_read_write),
        .acc_a(acc_a), .acc_b(acc_b), .condition_flags(condition_flags), .illegal_op(illegal_op));
    bus_mem mem_u (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_read_write(bus_read_write), .bus_rdata(bus_rdata));
    always #12.5 clk = ~clk;
    // ==========================================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put3(input logic [15:0] a, input logic [23:0] v);
        mem_u.mem[a] = v[23:16];
        mem_u.mem[a + 16'h0001] = v[15:8];
        mem_u.mem[a + 16'h0002] = v[7:0];
    endtask
    task automatic cyc(input logic [15:0] a, input logic rw, input logic [7:0] d);
        chk(bus_addr, a);
        chk(16'(bus_read_write), 16'(rw));
        if (!rw) chk(16'(bus_wdata), 16'(d));
        @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] a);
        cyc(a, 1'b1, 8'h00);
    endtask
    task automatic op(input int n);
        repeat (n) begin
            rd(pc);
            pc++;
        end
    endtask
    // Inherent forms read the next byte and throw it away
    task automatic inh();
        rd(pc);
        rd(pc + 16'h0001);
        pc++;
    endtask
    task automatic rmw(input logic [15:0] a, input logic [7:0] d);
        rd(a);
        rd(16'hFFFF);
        cyc(a, 1'b0, d);
    endtask
    task automatic flags(input logic [7:0] f);
        chk(16'(condition_flags), 16'(f));
    endtask
    // ==========================================
    // Scenarios
    task automatic t_shift_ext();
        put3(pc, 24'h782000);
        put3(pc + 16'h0003, 24'h772001);
        put3(16'h2000, 24'h400100);
        op(3);
        rmw(16'h2000, 8'h80);
        flags(8'hDA);
        op(3);
        rmw(16'h2001, 8'h00);
        flags(8'hD7);
    endtask
    task automatic t_and_modes();
        put3(pc, 24'h84FF94);
        put3(pc + 16'h0003, 24'h80F412);
        put3(pc + 16'h0006, 24'h34A406);
        put3(pc + 16'h0009, 24'h18E407);
        op(4);
        rd(16'h0080);
        op(3);
        rd(16'h1234);
        op(2);
        rd(16'hFFFF);
        rd(index_x + 16'h0006);
        op(3);
        rd(16'hFFFF);
        rd(index_y + 16'h0007);
        flags(8'hD5);
        chk({acc_a, acc_b}, 16'h0000);
    endtask
    task automatic t_shift_idx();
        put3(pc, 24'h681018);
        put3(pc + 16'h0003, 24'h672018);
        put3(pc + 16'h0006, 24'h683067);
        put3(pc + 16'h0009, 24'h300101);
        put3(16'h0110, 24'hFF0101);
        put3(16'h0130, 24'h810101);
        put3(16'h0220, 24'h020101);
        put3(16'h0230, 24'h400101);
        op(2);
        rd(16'hFFFF);
        rmw(index_x + 16'h0010, 8'hFE);
        flags(8'hD9);
        op(3);
        rd(16'hFFFF);
        rmw(index_y + 16'h0020, 8'h01);
        flags(8'hD0);
        op(3);
        rd(16'hFFFF);
        rmw(index_y + 16'h0030, 8'h80);
        flags(8'hDA);
        op(2);
        rd(16'hFFFF);
        rmw(index_x + 16'h0030, 8'hC0);
        flags(8'hD9);
    endtask
    task automatic t_acc_shifts();
        put3(pc, 24'h485847);
        put3(pc + 16'h0003, 24'h570501);
        repeat (4) begin
            inh();
            flags(8'hD4);
        end
        inh();
        rd(16'hFFFF);
        flags(8'hD4);
        chk({acc_a, acc_b}, 16'h0000);
        // Next byte is outside the group: one operand cycle, then refetch
        chk(16'(illegal_op), 16'h0000);
        rd(pc);
        rd(pc + 16'h0001);
        chk(16'(illegal_op), 16'h0001);
        rd(pc + 16'h0001);
    endtask
    // ==========================================
    // Run control
    task automatic test_done();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        test_done();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        index_x = 16'h0100;
        index_y = 16'h0200;
        pc = 16'h0000;
        num_errors = 0;
        compares = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_shift_ext();
        t_and_modes();
        t_shift_idx();
        t_acc_shifts();
        test_done();
    end
endmodule
